// File: rtl/ldc_host.sv
// Controller end: per-bank timing countdowns gating commands from software
module ldc_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [ldc_pkg::ADDR_W-1:0] addr,
    input wire logic [ldc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [ldc_pkg::DATA_W-1:0] rdata,
    // Link
    ldc_if.host lnk
);
    localparam int NB = ldc_pkg::NBANK;
    localparam logic [ldc_pkg::CNT_W-1:0] ZERO = 16'h0;
    localparam logic [ldc_pkg::CNT_W-1:0] ONE = 16'h1;

    logic [NB-1:0][ldc_pkg::CNT_W-1:0] act_ok_r;
    logic [NB-1:0][ldc_pkg::CNT_W-1:0] pre_ok_r;
    logic [NB-1:0][ldc_pkg::CNT_W-1:0] col_ok_r;
    logic [NB-1:0][ldc_pkg::CNT_W-1:0] open_r;
    logic [NB-1:0] is_open_r;
    logic [ldc_pkg::CNT_W-1:0] rrd_r, ccd_r, ppd_r, wtr_r, any_r, cke_r, sr_r;
    logic [3:0][ldc_pkg::CNT_W-1:0] faw_r;
    logic [1:0] faw_ptr_r;
    logic [ldc_pkg::DATA_W-1:0] cmd_r;
    logic cmd_pend_r, last_mwr_r, in_sr_r, sre_pend_r, overdue_r;
    logic [2:0] rate_r;
    logic wl_b_r, long_vref_r;
    logic [ldc_pkg::DATA_W-1:0] rd_cap_r;
    ldc_pkg::ldc_cmd_e pc;
    logic [ldc_pkg::BANK_W-1:0] pb;
    logic derate, fast, go;
    logic [ldc_pkg::LAT_W-1:0] wl;
    logic [ldc_pkg::CNT_W-1:0] ras_max;

    function automatic logic [ldc_pkg::CNT_W-1:0] dec(input logic [ldc_pkg::CNT_W-1:0] v);
        return (v == ZERO) ? ZERO : v - ONE;
    endfunction

    function automatic logic [ldc_pkg::CNT_W-1:0] mx(input logic [ldc_pkg::CNT_W-1:0] a,
                                                      input logic [ldc_pkg::CNT_W-1:0] b);
        return (a > b) ? a : b;
    endfunction

    assign pc = ldc_pkg::ldc_cmd_e'(cmd_r[3:0]);
    assign pb = cmd_r[6:4];
    assign derate = (lnk.refrate == ldc_pkg::REFRATE_DERATE);
    assign fast = (rate_r == ldc_pkg::RATE_TOP);
    assign wl = wl_b_r ? ldc_pkg::WL_B_TBL[rate_r] : ldc_pkg::WL_A_TBL[rate_r];
    // Scaled interval capped at the absolute limit
    assign ras_max = ldc_nck_min(lnk.refrate);

    function automatic logic [ldc_pkg::CNT_W-1:0] ldc_nck_min(input logic [2:0] r);
        longint t;
        t = longint'(ldc_pkg::RAS_MAX_REFI) * ldc_pkg::T_REFI_PS * (r == 3'h0 ? 1 : r) / 4;
        if (t > ldc_pkg::T_RAS_MAX_PS) t = ldc_pkg::T_RAS_MAX_PS;
        t = t / ldc_pkg::CLK_PS;
        if (t > 64'hffff) t = 64'hffff;
        return ldc_pkg::CNT_W'(t);
    endfunction

    // Decide whether the pending command may issue now
    always_comb begin
        go = cmd_pend_r && (any_r == ZERO) && !sre_pend_r;
        case (pc)
            ldc_pkg::LDC_ACT: go = go && act_ok_r[pb] == ZERO && rrd_r == ZERO
                                   && faw_r[faw_ptr_r] == ZERO && !is_open_r[pb];
            ldc_pkg::LDC_RD: go = go && ccd_r == ZERO && wtr_r == ZERO
                                  && col_ok_r[pb] == ZERO && is_open_r[pb];
            ldc_pkg::LDC_WR,
            ldc_pkg::LDC_MWR: go = go && ccd_r == ZERO && col_ok_r[pb] == ZERO && is_open_r[pb];
            ldc_pkg::LDC_PREPB: go = go && ppd_r == ZERO && pre_ok_r[pb] == ZERO;
            ldc_pkg::LDC_PREAB: go = go && ppd_r == ZERO && (pre_ok_r == '0);
            ldc_pkg::LDC_SRX: go = go && in_sr_r && sr_r == ZERO;
            default: go = go;
        endcase
    end

    // Per-bank countdowns
    always_ff @(posedge clk) begin
        if (rst) begin
            act_ok_r <= '0;
            pre_ok_r <= '0;
            col_ok_r <= '0;
            open_r <= '0;
            is_open_r <= '0;
        end else begin
            for (int b = 0; b < NB; b++) begin
                act_ok_r[b] <= dec(act_ok_r[b]);
                pre_ok_r[b] <= dec(pre_ok_r[b]);
                col_ok_r[b] <= dec(col_ok_r[b]);
                open_r[b] <= dec(open_r[b]);
                if (go && (pc == ldc_pkg::LDC_PREAB || (pc == ldc_pkg::LDC_PREPB && pb == b))) begin
                    is_open_r[b] <= 1'b0;
                    act_ok_r[b] <= mx(dec(act_ok_r[b]), (pc == ldc_pkg::LDC_PREAB)
                        ? ldc_pkg::ldc_nck(ldc_pkg::T_RPAB_PS, ldc_pkg::T_RP_NCK)
                          + (derate ? ldc_pkg::ldc_nck(ldc_pkg::T_DERATE_PS, 1) : ZERO)
                        : ldc_pkg::ldc_nck(ldc_pkg::T_RPPB_PS, ldc_pkg::T_RP_NCK)
                          + (derate ? ldc_pkg::ldc_nck(ldc_pkg::T_DERATE_PS, 1) : ZERO));
                end
            end
            if (go && pc == ldc_pkg::LDC_ACT) begin
                is_open_r[pb] <= 1'b1;
                open_r[pb] <= ras_max;
                // Row active plus derating before precharge, then the precharge time
                pre_ok_r[pb] <= ldc_pkg::ldc_nck(ldc_pkg::T_RAS_PS + (derate ?
                    ldc_pkg::T_DERATE_PS : 0), ldc_pkg::T_RAS_NCK);
                col_ok_r[pb] <= ldc_pkg::ldc_nck(ldc_pkg::T_RCD_PS + (derate ?
                    ldc_pkg::T_DERATE_PS : 0), ldc_pkg::T_RCD_NCK);
                act_ok_r[pb] <= ldc_pkg::ldc_nck(ldc_pkg::T_RAS_PS + ldc_pkg::T_RPPB_PS
                    + (derate ? ldc_pkg::T_DERATE_RC_PS : 0), ldc_pkg::T_RAS_NCK);
            end
            if (go && pc == ldc_pkg::LDC_RD) begin
                pre_ok_r[pb] <= mx(dec(pre_ok_r[pb]),
                    ldc_pkg::ldc_nck(ldc_pkg::T_RTP_PS, ldc_pkg::T_RTP_NCK));
            end
            if (go && (pc == ldc_pkg::LDC_WR || pc == ldc_pkg::LDC_MWR)) begin
                pre_ok_r[pb] <= mx(dec(pre_ok_r[pb]), 16'(wl) + 16'(ldc_pkg::BURST_NCK)
                    + ldc_pkg::ldc_nck(ldc_pkg::T_WR_PS, ldc_pkg::T_WR_NCK));
            end
        end
    end

    // Shared countdowns
    always_ff @(posedge clk) begin
        if (rst) begin
            rrd_r <= '0;
            ccd_r <= '0;
            ppd_r <= '0;
            wtr_r <= '0;
            faw_r <= '0;
            faw_ptr_r <= '0;
            last_mwr_r <= 1'b0;
        end else begin
            rrd_r <= dec(rrd_r);
            ccd_r <= dec(ccd_r);
            ppd_r <= dec(ppd_r);
            wtr_r <= dec(wtr_r);
            for (int i = 0; i < ldc_pkg::FAW_ACTS; i++) faw_r[i] <= dec(faw_r[i]);
            if (go && pc == ldc_pkg::LDC_ACT) begin
                rrd_r <= ldc_pkg::ldc_nck((fast ? ldc_pkg::T_RRD_FAST_PS : ldc_pkg::T_RRD_PS)
                    + (derate ? ldc_pkg::T_DERATE_PS : 0), ldc_pkg::T_RRD_NCK);
                faw_r[faw_ptr_r] <= ldc_pkg::ldc_nck(fast ? ldc_pkg::T_FAW_FAST_PS
                    : ldc_pkg::T_FAW_PS, 1);
                faw_ptr_r <= faw_ptr_r + 2'h1;
            end
            if (go && (pc == ldc_pkg::LDC_RD || pc == ldc_pkg::LDC_WR
                       || pc == ldc_pkg::LDC_MWR)) begin
                last_mwr_r <= (pc == ldc_pkg::LDC_MWR);
                ccd_r <= 16'(((pc == ldc_pkg::LDC_MWR && last_mwr_r) ? ldc_pkg::T_CCDMW_NCK
                    : ldc_pkg::T_CCD_NCK) - 1);
            end
            if (go && (pc == ldc_pkg::LDC_WR || pc == ldc_pkg::LDC_MWR)) begin
                wtr_r <= 16'(wl) + 16'(ldc_pkg::BURST_NCK)
                    + ldc_pkg::ldc_nck(ldc_pkg::T_WTR_PS, ldc_pkg::T_WTR_NCK);
            end
            if (go && (pc == ldc_pkg::LDC_PREPB || pc == ldc_pkg::LDC_PREAB)) begin
                ppd_r <= 16'(ldc_pkg::T_PPD_NCK - 1);
            end
        end
    end

    // Self refresh, training exit and the global hold-off
    always_ff @(posedge clk) begin
        if (rst) begin
            any_r <= '0;
            cke_r <= '0;
            sr_r <= '0;
            in_sr_r <= 1'b0;
            sre_pend_r <= 1'b0;
            lnk.cke <= 1'b1;
        end else begin
            any_r <= dec(any_r);
            cke_r <= dec(cke_r);
            sr_r <= dec(sr_r);
            if (go && pc == ldc_pkg::LDC_SRE) begin
                in_sr_r <= 1'b1;
                sre_pend_r <= 1'b1;
                cke_r <= ldc_pkg::C_ESCKE;
                sr_r <= ldc_pkg::C_SR;
            end else if (sre_pend_r && cke_r <= ONE) begin
                lnk.cke <= 1'b0;
                sre_pend_r <= 1'b0;
            end
            if (go && pc == ldc_pkg::LDC_SRX) begin
                in_sr_r <= 1'b0;
                lnk.cke <= 1'b1;
                any_r <= ldc_pkg::ldc_nck(ldc_pkg::T_RFCAB_PS + ldc_pkg::T_XSR_ADD_PS,
                    ldc_pkg::T_XSR_NCK);
            end
            if (go && pc == ldc_pkg::LDC_CBT_EXIT) begin
                any_r <= ldc_pkg::ldc_nck(long_vref_r ? ldc_pkg::T_XCBT_LONG_PS
                    : ldc_pkg::T_XCBT_PS, ldc_pkg::T_XCBT_NCK);
            end
        end
    end

    // Command drive and write data at the write latency
    logic [63:0] wpipe_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            lnk.cmd <= ldc_pkg::LDC_NOP;
            lnk.bank <= '0;
            lnk.wdata <= '0;
            lnk.wvalid <= 1'b0;
            wpipe_r <= '0;
        end else begin
            lnk.cmd <= go ? pc : ldc_pkg::LDC_NOP;
            lnk.bank <= go ? pb : lnk.bank;
            wpipe_r <= {1'b0, wpipe_r[63:1]};
            if (go && (pc == ldc_pkg::LDC_WR || pc == ldc_pkg::LDC_MWR)) begin
                wpipe_r[wl] <= 1'b1;
            end
            lnk.wvalid <= wpipe_r[1];
            if (wpipe_r[1]) lnk.wdata <= {8'h00, cmd_r[ldc_pkg::DATA_W-1:8]};
        end
    end

    // Register port
    always_ff @(posedge clk) begin
        if (rst) begin
            cmd_r <= '0;
            cmd_pend_r <= 1'b0;
            rate_r <= ldc_pkg::RATE_TOP;
            wl_b_r <= 1'b0;
            long_vref_r <= 1'b0;
            rd_cap_r <= '0;
            overdue_r <= 1'b0;
            rdata <= '0;
        end else begin
            if (go) cmd_pend_r <= 1'b0;
            if (wr && addr == ldc_pkg::REG_CMD && !cmd_pend_r) begin
                cmd_r <= wdata;
                cmd_pend_r <= 1'b1;
            end
            if (wr && addr == ldc_pkg::REG_CFG) begin
                rate_r <= wdata[2:0];
                wl_b_r <= wdata[3];
                long_vref_r <= wdata[4];
            end
            if (lnk.rvalid) rd_cap_r <= lnk.rdata;
            else if (lnk.cbt_valid) rd_cap_r <= lnk.cbt_data;
            if (rd && addr == ldc_pkg::REG_STATUS) begin
                overdue_r <= 1'b0;
            end
            // Row held past its limit: sticky until status read, set wins
            for (int b = 0; b < NB; b++) begin
                if (is_open_r[b] && open_r[b] == ONE) overdue_r <= 1'b1;
            end
            rdata <= '0;
            if (rd) begin
                case (addr)
                    ldc_pkg::REG_CMD: rdata <= cmd_r;
                    ldc_pkg::REG_CFG: rdata <= {27'h0, long_vref_r, wl_b_r, rate_r};
                    ldc_pkg::REG_STATUS: rdata <= {16'h0, is_open_r, 2'h0, derate,
                        overdue_r, in_sr_r, lnk.cke, cmd_pend_r, lnk.cbt_valid};
                    ldc_pkg::REG_RDATA: rdata <= rd_cap_r;
                    default: rdata <= '0;
                endcase
            end
        end
    end
endmodule

// File: pkg/ldc_pkg.sv
// Constants, types and helpers shared by both ends of the DRAM command-timing link
// Overview of operation
// - Read data after RL, 6..36 clocks, no inversion
// - With inversion, read latency 6..40 clocks
// - Write latency set A spans 4..18 clocks
// - Write latency set B spans 4..34 clocks
// - Same-bank activates spaced row active plus precharge
// - Self refresh held max(15 ns, 3 clocks)
// - After self refresh exit wait refresh+7.5 ns
// - Column spacing 8 clocks, masked writes 32; code waits 32 only after a masked write that followed one, else 8
// - Precharge after read max(7.5 ns, 8 clocks)
// - Single-bank precharge to activate max(18 ns, 3)
// - All-bank precharge to activate max(21 ns, 3)
// - Write recovery max(18 ns, 4) before precharge
// - Write-to-read max(10 ns, 8) after write data
// - Bank-to-bank activate max(4 clocks, 10/7.5 ns)
// - At most four activates per 40/30 ns window
// - Explicit precharges at least 4 clocks apart
// - Clock enable low after entry max(3, 1.75 ns)
// - Row open at most min(9 intervals, 70.2 us); code only flags an overrun in the status register
// - Derating reported as refresh-rate field 110b
// - Derating adds 1.875 ns, same-bank period 3.75 ns
// - Training samples too close lost, last valid in 20 ns
// - After training exit wait max(5, 200/250 ns)
package ldc_pkg;
    localparam int CLK_PS = 5000;
    localparam int NBANK = 8;
    localparam int BANK_W = 3;
    localparam int LAT_W = 6;
    localparam int CNT_W = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Latency tables, index = data-rate step 0 (lowest) .. 7 (top)
    localparam logic [7:0][5:0] RL_A_TBL = {6'd36, 6'd32, 6'd28, 6'd24, 6'd20, 6'd14, 6'd10, 6'd6};
    localparam logic [7:0][5:0] RL_B_TBL = {6'd40, 6'd36, 6'd32, 6'd28, 6'd22, 6'd16, 6'd12, 6'd6};
    localparam logic [7:0][5:0] WL_A_TBL = {6'd18, 6'd16, 6'd14, 6'd12, 6'd10, 6'd8, 6'd6, 6'd4};
    localparam logic [7:0][5:0] WL_B_TBL = {6'd34, 6'd30, 6'd26, 6'd22, 6'd18, 6'd12, 6'd8, 6'd4};
    localparam logic [2:0] RATE_TOP = 3'h7;

    // Times in picoseconds, minimum clocks beside those that have one
    localparam int T_RAS_PS = 42000;
    localparam int T_RAS_NCK = 3;
    localparam int T_RPPB_PS = 18000;
    localparam int T_RPAB_PS = 21000;
    localparam int T_RP_NCK = 3;
    localparam int T_SR_PS = 15000;
    localparam int T_SR_NCK = 3;
    localparam int T_XSR_ADD_PS = 7500;
    localparam int T_XSR_NCK = 2;
    localparam int T_RFCAB_PS = 280000;
    localparam int T_CCD_NCK = 8;
    localparam int T_CCDMW_NCK = 32;
    localparam int T_RTP_PS = 7500;
    localparam int T_RTP_NCK = 8;
    localparam int T_RCD_PS = 18000;
    localparam int T_RCD_NCK = 4;
    localparam int T_WR_PS = 18000;
    localparam int T_WR_NCK = 4;
    localparam int T_WTR_PS = 10000;
    localparam int T_WTR_NCK = 8;
    localparam int T_RRD_PS = 10000;
    localparam int T_RRD_FAST_PS = 7500;
    localparam int T_RRD_NCK = 4;
    localparam int T_FAW_PS = 40000;
    localparam int T_FAW_FAST_PS = 30000;
    localparam int T_PPD_NCK = 4;
    localparam int T_ESCKE_PS = 1750;
    localparam int T_ESCKE_NCK = 3;
    localparam int T_RAS_MAX_PS = 70200000;
    localparam int T_REFI_PS = 3904000;
    localparam int RAS_MAX_REFI = 9;
    localparam int T_DERATE_PS = 1875;
    localparam int T_DERATE_RC_PS = 3750;
    localparam int T_ADR_PS = 20000;
    localparam int T_XCBT_PS = 200000;
    localparam int T_XCBT_LONG_PS = 250000;
    localparam int T_XCBT_NCK = 5;
    localparam int BURST_NCK = 8;
    localparam int FAW_ACTS = 4;

    localparam logic [2:0] REFRATE_DERATE = 3'b110;
    localparam logic [2:0] REFRATE_NORMAL = 3'b011;

    // Least clocks for a time, never below a clock minimum
    function automatic logic [CNT_W-1:0] ldc_nck(input int ps, input int nck);
        int c;
        c = (ps + CLK_PS - 1) / CLK_PS;
        if (c < nck) c = nck;
        if (c < 1) c = 1;
        return CNT_W'(c);
    endfunction

    localparam logic [CNT_W-1:0] C_ADR = CNT_W'(T_ADR_PS / CLK_PS);
    localparam logic [CNT_W-1:0] C_CACD = ldc_nck(T_ADR_PS, 1);
    localparam logic [CNT_W-1:0] C_ESCKE = ldc_nck(T_ESCKE_PS, T_ESCKE_NCK);
    localparam logic [CNT_W-1:0] C_SR = ldc_nck(T_SR_PS, T_SR_NCK);

    typedef enum logic [3:0] {
        LDC_NOP, LDC_ACT, LDC_RD, LDC_WR, LDC_MWR, LDC_PREPB, LDC_PREAB,
        LDC_SRE, LDC_SRX, LDC_CBT_ENTER, LDC_CBT_SAMPLE, LDC_CBT_EXIT
    } ldc_cmd_e;

    // Host register offsets
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CFG = 4'h1;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
    localparam logic [ADDR_W-1:0] REG_RDATA = 4'h3;
endpackage

// File: pkg/ldc_if.sv
// Command/address and data link between controller and DRAM model end
interface ldc_if (input wire logic clk);
    ldc_pkg::ldc_cmd_e cmd;
    logic [ldc_pkg::BANK_W-1:0] bank;
    logic cke;
    logic [ldc_pkg::DATA_W-1:0] wdata;
    logic wvalid;
    logic [ldc_pkg::DATA_W-1:0] rdata;
    logic rvalid;
    logic [2:0] refrate;
    logic [ldc_pkg::DATA_W-1:0] cbt_data;
    logic cbt_valid;
    modport dev (input cmd, bank, cke, wdata, wvalid,
                 output rdata, rvalid, refrate, cbt_data, cbt_valid);
    modport host (output cmd, bank, cke, wdata, wvalid,
                  input rdata, rvalid, refrate, cbt_data, cbt_valid);
endinterface

// File: rtl/ldc_dev.sv
// DRAM end: latencies, derating report and training sample return
module ldc_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    ldc_if.dev lnk,
    // Configuration
    input wire logic [2:0] rate_sel,
    input wire logic dbi_en,
    input wire logic wl_set_b,
    input wire logic hot,
    // Captured write data
    output logic [ldc_pkg::DATA_W-1:0] wr_data,
    output logic wr_valid
);
    localparam int PIPE = 64;
    logic [PIPE-1:0] rd_pipe_r;
    logic [PIPE-1:0] wr_pipe_r;
    logic [ldc_pkg::LAT_W-1:0] rl;
    logic [ldc_pkg::LAT_W-1:0] wl;
    logic [ldc_pkg::DATA_W-1:0] rd_cnt_r;
    logic [ldc_pkg::CNT_W-1:0] cbt_cnt_r;
    logic [ldc_pkg::CNT_W-1:0] cbt_gap_r;
    logic [ldc_pkg::DATA_W-1:0] cbt_hold_r;
    logic cbt_pend_r;

    assign rl = dbi_en ? ldc_pkg::RL_B_TBL[rate_sel] : ldc_pkg::RL_A_TBL[rate_sel];
    assign wl = wl_set_b ? ldc_pkg::WL_B_TBL[rate_sel] : ldc_pkg::WL_A_TBL[rate_sel];

    // Reads: data driven rl clocks after the command
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_pipe_r <= '0;
        end else begin
            // Marker walks down to bit 0, which launches the data
            rd_pipe_r <= {1'b0, rd_pipe_r[PIPE-1:1]};
            if (lnk.cmd == ldc_pkg::LDC_RD) begin
                rd_pipe_r[rl - 6'h1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lnk.rvalid <= 1'b0;
            lnk.rdata <= '0;
            rd_cnt_r <= '0;
        end else begin
            lnk.rvalid <= rd_pipe_r[PIPE-1] ? 1'b0 : 1'b0;
            if (rd_pipe_r[0]) begin
                lnk.rvalid <= 1'b1;
                lnk.rdata <= rd_cnt_r;
                rd_cnt_r <= rd_cnt_r + 32'h1;
            end
        end
    end

    // Writes: data sampled wl clocks after the command
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_pipe_r <= '0;
        end else begin
            wr_pipe_r <= {1'b0, wr_pipe_r[PIPE-1:1]};
            if (lnk.cmd == ldc_pkg::LDC_WR || lnk.cmd == ldc_pkg::LDC_MWR) begin
                wr_pipe_r[wl - 6'h1] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_valid <= 1'b0;
            wr_data <= '0;
        end else begin
            wr_valid <= wr_pipe_r[0] && lnk.wvalid;
            if (wr_pipe_r[0]) begin
                wr_data <= lnk.wdata;
            end
        end
    end

    // Derating flag shown through the refresh-rate field
    always_ff @(posedge clk) begin
        if (rst) begin
            lnk.refrate <= ldc_pkg::REFRATE_NORMAL;
        end else begin
            lnk.refrate <= hot ? ldc_pkg::REFRATE_DERATE : ldc_pkg::REFRATE_NORMAL;
        end
    end

    // Training: a sample followed too soon by the next one is dropped
    always_ff @(posedge clk) begin
        if (rst) begin
            cbt_gap_r <= '0;
            cbt_cnt_r <= '0;
            cbt_pend_r <= 1'b0;
            cbt_hold_r <= '0;
            lnk.cbt_valid <= 1'b0;
            lnk.cbt_data <= '0;
        end else begin
            if (cbt_gap_r != '0) begin
                cbt_gap_r <= cbt_gap_r - 16'h1;
            end
            if (cbt_cnt_r != '0) begin
                cbt_cnt_r <= cbt_cnt_r - 16'h1;
            end
            if (lnk.cmd == ldc_pkg::LDC_CBT_SAMPLE) begin
                cbt_hold_r <= {{(ldc_pkg::DATA_W-ldc_pkg::BANK_W){1'b0}}, lnk.bank};
                cbt_gap_r <= ldc_pkg::C_CACD;
                cbt_cnt_r <= ldc_pkg::C_ADR;
                cbt_pend_r <= 1'b1;
                lnk.cbt_valid <= 1'b0;
            end else if (cbt_pend_r && cbt_gap_r <= 16'h1 && cbt_cnt_r <= 16'h1) begin
                // Only the last sample, once its spacing was met, reports
                lnk.cbt_valid <= 1'b1;
                lnk.cbt_data <= cbt_hold_r;
                cbt_pend_r <= 1'b0;
            end else if (lnk.cmd == ldc_pkg::LDC_CBT_EXIT) begin
                lnk.cbt_valid <= 1'b0;
            end
        end
    end
endmodule

// File: testbench/ldc_props.sv
// Timing checks on the command link between the two ends
module ldc_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire ldc_pkg::ldc_cmd_e cmd,
    input wire logic cke,
    input wire logic wvalid,
    input wire logic cbt_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int XSR_CK = (ldc_pkg::T_RFCAB_PS + ldc_pkg::T_XSR_ADD_PS + ldc_pkg::CLK_PS - 1)
        / ldc_pkg::CLK_PS;
    logic [7:0] xsr_r;
    logic col;
    logic pre;
    logic act;
    assign col = cmd inside {ldc_pkg::LDC_RD, ldc_pkg::LDC_WR, ldc_pkg::LDC_MWR};
    assign pre = cmd inside {ldc_pkg::LDC_PREPB, ldc_pkg::LDC_PREAB};
    assign act = cmd == ldc_pkg::LDC_ACT;
    // Saturates so a long quiet spell never wraps back into the forbidden range
    always_ff @(posedge clk) begin
        if (rst) xsr_r <= 8'hff;
        else if (cmd == ldc_pkg::LDC_SRX) xsr_r <= 8'h00;
        else if (xsr_r != 8'hff) xsr_r <= xsr_r + 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_cbt_quiet;
        cmd == ldc_pkg::LDC_CBT_SAMPLE ##1 (cmd == ldc_pkg::LDC_NOP) [*5];
    endsequence
    a_col_spacing: assert property (col |=> !col [*7])
        else $error("column commands too close");
    a_pre_spacing: assert property (pre |=> !pre [*3])
        else $error("precharges too close");
    a_act_spacing: assert property (act |=> !act [*3])
        else $error("activates too close");
    a_pab_to_act: assert property (cmd == ldc_pkg::LDC_PREAB |=> !act [*4])
        else $error("activate too soon after all-bank precharge");
    a_sre_cke_hold: assert property (cmd == ldc_pkg::LDC_SRE |=> cke [*2])
        else $error("clock enable dropped too soon");
    a_rd_to_pre: assert property (cmd == ldc_pkg::LDC_RD |=> !pre [*7])
        else $error("precharge too soon after read");
    a_wr_to_rd: assert property (wvalid |=> (cmd != ldc_pkg::LDC_RD) [*7])
        else $error("read too soon after write data");
    a_sr_min_time: assert property (cmd == ldc_pkg::LDC_SRE |=> (cmd != ldc_pkg::LDC_SRX) [*2])
        else $error("self refresh left too soon");
    a_xsr_wait: assert property (!(cmd inside {ldc_pkg::LDC_NOP, ldc_pkg::LDC_SRX})
        |-> xsr_r >= XSR_CK - 1) else $error("command too soon after self refresh exit");
    a_cbt_result: assert property (s_cbt_quiet |-> cbt_valid)
        else $error("training sample not returned");
endmodule

// File: testbench/ldc_tb_top.sv
// Self-checking bench: controller and memory ends joined over the link
`define check(a, e) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module ldc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [2:0] rate; int rla; int rlb; int wla; int wlb;} ldc_row_s;
    ldc_row_s rows [8] = '{'{3'h0, 6, 6, 4, 4}, '{3'h1, 10, 12, 6, 8}, '{3'h2, 14, 16, 8, 12},
        '{3'h3, 20, 22, 10, 18}, '{3'h4, 24, 28, 12, 22}, '{3'h5, 28, 32, 14, 26},
        '{3'h6, 32, 36, 16, 30}, '{3'h7, 36, 40, 18, 34}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] st;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic dbi_en = 1'b0;
    logic wl_set_b = 1'b0;
    logic hot = 1'b0;
    logic [2:0] rate_sel = 3'h0;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    int exp_n;
    logic [31:0] wr_got;
    logic wv_got;
    always #2.5 clk = ~clk;
    ldc_if lnk_if (.clk(clk));
    ldc_dev u_ldc_dev (.clk(clk), .rst(rst), .lnk(lnk_if), .rate_sel(rate_sel), .dbi_en(dbi_en),
        .wl_set_b(wl_set_b), .hot(hot), .wr_data(wr_got), .wr_valid(wv_got));
    ldc_host u_ldc_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .lnk(lnk_if));
    ldc_props u_ldc_props (.clk(clk), .rst(rst), .cmd(lnk_if.cmd), .cke(lnk_if.cke),
        .wvalid(lnk_if.wvalid), .cbt_valid(lnk_if.cbt_valid));
    task automatic test_done;
        if (miscompares == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        st = rdata;
    endtask
    // Stalled commands may wait out long recovery times
    task automatic seen(input ldc_pkg::ldc_cmd_e c);
        int k;
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (lnk_if.cmd !== c && k < 500);
        if (k == 500) miscompares++;
    endtask
    task automatic go(input ldc_pkg::ldc_cmd_e c, input logic [2:0] b);
        wr_reg(ldc_pkg::REG_CMD, {24'h5a5a5a, 1'b0, b, c});
        seen(c);
    endtask
    task automatic lat(input ldc_pkg::ldc_cmd_e c, output int m);
        go(c, 3'h0);
        m = 0;
        do begin
            @(negedge clk);
            m++;
        end while (((c == ldc_pkg::LDC_RD) ? lnk_if.rvalid : lnk_if.wvalid) !== 1'b1 && m < 100);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ldc_pkg::REG_STATUS);
        `check(st, 32'h0000_0004)
        `check(lnk_if.refrate, ldc_pkg::REFRATE_NORMAL)
        go(ldc_pkg::LDC_ACT, 3'h0);
        foreach (rows[i]) for (int j = 0; j < 4; j++) begin
            @(posedge clk);
            rate_sel <= rows[i].rate;
            dbi_en <= j[0];
            wl_set_b <= j[0];
            wr_reg(ldc_pkg::REG_CFG, {28'h0, j[0], rows[i].rate});
            lat(j[1] ? ldc_pkg::LDC_WR : ldc_pkg::LDC_RD, n);
            // Read data leaves rl clocks after the device samples the command, one clock after it is driven
            exp_n = j[0] ? (j[1] ? rows[i].wlb : rows[i].rlb + 1)
                : (j[1] ? rows[i].wla : rows[i].rla + 1);
            `check(n, exp_n)
            if (j[1]) begin
                @(negedge clk);
                `check(wv_got, 1'b1)
                `check(wr_got, 32'h005a_5a5a)
            end
        end
        @(posedge clk);
        hot <= 1'b1;
        repeat (2) @(posedge clk);
        rd_reg(ldc_pkg::REG_STATUS);
        `check(lnk_if.refrate, ldc_pkg::REFRATE_DERATE)
        `check(st[5], 1'b1)
        go(ldc_pkg::LDC_PREAB, 3'h0);
        wr_reg(ldc_pkg::REG_CMD, {28'h0, ldc_pkg::LDC_ACT});
        rd_reg(ldc_pkg::REG_STATUS);
        `check(st[1], 1'b1)
        seen(ldc_pkg::LDC_ACT);
        go(ldc_pkg::LDC_PREPB, 3'h0);
        go(ldc_pkg::LDC_SRE, 3'h0);
        rd_reg(ldc_pkg::REG_STATUS);
        `check(st[3], 1'b1)
        go(ldc_pkg::LDC_SRX, 3'h0);
        go(ldc_pkg::LDC_ACT, 3'h2);
        go(ldc_pkg::LDC_PREAB, 3'h0);
        go(ldc_pkg::LDC_CBT_ENTER, 3'h0);
        go(ldc_pkg::LDC_CBT_SAMPLE, 3'h0);
        go(ldc_pkg::LDC_CBT_SAMPLE, 3'h0);
        repeat (8) @(negedge clk);
        `check(lnk_if.cbt_valid, 1'b1)
        go(ldc_pkg::LDC_CBT_EXIT, 3'h0);
        test_done;
    end
    initial begin
        // Some 40 commands of under 500 cycles each fit well inside
        #200000;
        miscompares++;
        test_done;
    end
endmodule
